// ---- src/frc_ctrl.sv ----
// flash rewrite control: protected control registers and erase/program sequencer
//
// Contract
// - interrupt during ROM rewrite aborts, resets flash
// - interrupt handler starts after recovery period
// - watchdog keeps counting during flash command
// - protected bits set by write 0 then 1
// - lock bits cleared by write 1 then 0
// - ready flag 0 while busy; no stop/wait
// - data flash wait bit gives 4-cycle access
// - low-current read lowers flash read current
// - suspend request suspends erase after latency; clear resumes
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module frc_ctrl #(
	parameter int ERASE_CYCLES = frc_pkg::ERASE_CYC,
	parameter int PROG_CYCLES  = frc_pkg::PROG_CYC
) (
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	input  wire logic [frc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	input  wire logic                      irq_ack,
	input  wire logic                      target_is_rom,
	input  wire logic                      ram_resident_rewrite_mode,
	input  wire logic                      rom_resident_rewrite_mode,
	output logic                           irq_hold,
	output logic                           flash_reset,
	output logic                           watchdog_run,
	output logic                           low_current_read,
	output logic      [2:0]                df_access_cycles
);
	frc_pkg::frc_state_e state;
	frc_pkg::frc_state_e next_state;
	logic [frc_pkg::CNT_W-1:0] cnt;
	logic [frc_pkg::CNT_W-1:0] next_cnt;
	logic [7:0] flash_ctrl_reg_a;
	logic [7:0] flash_ctrl_reg_b;
	logic [7:0] flash_ctrl_reg_c;
	logic [7:0] flash_state_reg;
	logic [7:0] hw_clr_a;
	logic [7:0] hw_set_c;

	wire hit_a = reg_wr && (reg_addr == frc_pkg::OFF_CTRL_A);
	wire hit_b = reg_wr && (reg_addr == frc_pkg::OFF_CTRL_B);
	wire hit_c = reg_wr && (reg_addr == frc_pkg::OFF_CTRL_C);

	wire cpu_rewrite_enable      = flash_ctrl_reg_a[frc_pkg::BIT_CPU_REWRITE];
	wire erase_cmd               = flash_ctrl_reg_a[frc_pkg::BIT_ERASE_CMD];
	wire prog_cmd                = flash_ctrl_reg_a[frc_pkg::BIT_PROG_CMD];
	wire suspend_enable_bit      = flash_ctrl_reg_c[frc_pkg::BIT_SUSP_EN];
	wire suspend_request_bit     = flash_ctrl_reg_c[frc_pkg::BIT_SUSP_REQ];
	wire irq_auto_suspend_enable = flash_ctrl_reg_c[frc_pkg::BIT_IRQ_AUTO_SUSP];
	wire data_flash_wait_select  = flash_ctrl_reg_c[frc_pkg::BIT_DF_WAIT];
	wire low_current_read_enable = flash_ctrl_reg_c[frc_pkg::BIT_LOW_CUR_READ];
	wire rewrite_mode            = ram_resident_rewrite_mode | rom_resident_rewrite_mode;
	// a command starts only with rewrite enabled and a rewrite mode active
	wire start_ok    = cpu_rewrite_enable && rewrite_mode;
	// a suspended erase is not busy and reports ready
	wire busy_op     = (state == frc_pkg::FRC_ERASE) || (state == frc_pkg::FRC_PROG)
		|| (state == frc_pkg::FRC_SUSP_WAIT);
	// rom target only: interrupt aborts the busy operation, whether or not suspend is usable
	wire abort_req   = irq_ack && target_is_rom && busy_op;
	wire auto_susp   = irq_ack && !target_is_rom && (state == frc_pkg::FRC_ERASE)
		&& irq_auto_suspend_enable && suspend_enable_bit;
	wire cnt_done    = (cnt == '0);

	frc_guard #(
		.RESET_VAL (frc_pkg::RST_CTRL_A),
		.SET_MASK  (frc_pkg::SET_MASK_A),
		.CLR_MASK  (8'h00)
	) u_reg_a (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.wr_any  (reg_wr),
		.wr_hit  (hit_a),
		.wdata   (reg_wdata),
		.hw_set  (8'h00),
		.hw_clr  (hw_clr_a),
		.value   (flash_ctrl_reg_a)
	);
	frc_guard #(
		.RESET_VAL (frc_pkg::RST_CTRL_B),
		.SET_MASK  (frc_pkg::SET_MASK_B),
		.CLR_MASK  (frc_pkg::CLR_MASK_B)
	) u_reg_b (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.wr_any  (reg_wr),
		.wr_hit  (hit_b),
		.wdata   (reg_wdata),
		.hw_set  (8'h00),
		.hw_clr  (8'h00),
		.value   (flash_ctrl_reg_b)
	);
	frc_guard #(
		.RESET_VAL (frc_pkg::RST_CTRL_C),
		.SET_MASK  (frc_pkg::SET_MASK_C),
		.CLR_MASK  (8'h00)
	) u_reg_c (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.wr_any  (reg_wr),
		.wr_hit  (hit_c),
		.wdata   (reg_wdata),
		.hw_set  (hw_set_c),
		.hw_clr  (8'h00),
		.value   (flash_ctrl_reg_c)
	);

	// command bits self-clear when the sequencer takes or ends them
	always_comb begin
		hw_clr_a = 8'h00;
		hw_set_c = 8'h00;
		if (state != frc_pkg::FRC_IDLE || abort_req) begin
			hw_clr_a[frc_pkg::BIT_ERASE_CMD] = 1'b1;
			hw_clr_a[frc_pkg::BIT_PROG_CMD]  = 1'b1;
		end
		if (auto_susp) hw_set_c[frc_pkg::BIT_SUSP_REQ] = 1'b1;
	end

	always_comb begin
		next_state = state;
		next_cnt   = (cnt_done) ? cnt : cnt - 1'b1;
		unique case (state)
			frc_pkg::FRC_IDLE: begin
				if (start_ok && erase_cmd) begin
					next_state = frc_pkg::FRC_ERASE;
					next_cnt   = frc_pkg::CNT_W'(ERASE_CYCLES - 1);
				end else if (start_ok && prog_cmd) begin
					next_state = frc_pkg::FRC_PROG;
					next_cnt   = frc_pkg::CNT_W'(PROG_CYCLES - 1);
				end
			end
			frc_pkg::FRC_ERASE: begin
				// a suspend request overrides completion in the same cycle
				if (cnt_done) next_state = frc_pkg::FRC_IDLE;
				if (suspend_enable_bit && (suspend_request_bit || auto_susp)) begin
					next_state = frc_pkg::FRC_SUSP_WAIT;
					next_cnt   = frc_pkg::CNT_W'(frc_pkg::SUSP_LAT_CYC - 1);
				end
			end
			frc_pkg::FRC_SUSP_WAIT: begin
				if (cnt_done) begin
					next_state = frc_pkg::FRC_SUSPENDED;
					next_cnt   = '0;
				end
			end
			frc_pkg::FRC_SUSPENDED: begin
				// resume with half the erase time still to run
				if (!suspend_request_bit) begin
					next_state = frc_pkg::FRC_ERASE;
					next_cnt   = frc_pkg::CNT_W'(ERASE_CYCLES / 2);
				end
			end
			frc_pkg::FRC_PROG: begin
				if (cnt_done) next_state = frc_pkg::FRC_IDLE;
			end
			frc_pkg::FRC_RECOVER: begin
				if (cnt_done) next_state = frc_pkg::FRC_IDLE;
			end
		endcase
		// abort overrides every other transition
		if (abort_req) begin
			next_state = frc_pkg::FRC_RECOVER;
			next_cnt   = frc_pkg::CNT_W'(frc_pkg::RECOVER_CYC - 1);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state <= frc_pkg::FRC_IDLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	always_comb begin
		flash_state_reg = 8'h00;
		flash_state_reg[frc_pkg::BIT_READY]     = !busy_op && state != frc_pkg::FRC_RECOVER;
		flash_state_reg[frc_pkg::BIT_SUSPENDED] = (state == frc_pkg::FRC_SUSPENDED);
	end

	// unmapped offsets read as zero
	wire [7:0] rd_mux = (reg_addr == frc_pkg::OFF_CTRL_A) ? flash_ctrl_reg_a :
		(reg_addr == frc_pkg::OFF_CTRL_B) ? flash_ctrl_reg_b :
		(reg_addr == frc_pkg::OFF_CTRL_C) ? flash_ctrl_reg_c :
		(reg_addr == frc_pkg::OFF_STATE)  ? flash_state_reg : 8'h00;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata        <= 8'h00;
			df_access_cycles <= 3'(frc_pkg::DF_FAST_CYC);
			low_current_read <= 1'b0;
		end else begin
			reg_rdata        <= reg_rd ? rd_mux : 8'h00;
			df_access_cycles <= data_flash_wait_select ? 3'(frc_pkg::DF_WAIT_CYC)
				: 3'(frc_pkg::DF_FAST_CYC);
			low_current_read <= low_current_read_enable;
		end
	end

	// hold interrupt entry during abort and recovery
	assign irq_hold     = abort_req || (state == frc_pkg::FRC_RECOVER);
	assign flash_reset  = (state == frc_pkg::FRC_RECOVER);
	assign watchdog_run = 1'b1;
endmodule // frc_ctrl
`default_nettype wire

// ---- src/frc_guard.sv ----
// protected-write guard for one control register
`timescale 1ns/1ps
`default_nettype none
module frc_guard #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] SET_MASK  = 8'h00,
	parameter logic [7:0] CLR_MASK  = 8'h00
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       wr_any,
	input  wire logic       wr_hit,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] hw_set,
	input  wire logic [7:0] hw_clr,
	output logic      [7:0] value
);
	logic [7:0] prev;
	logic       prev_ok;
	logic [7:0] next_value;
	wire  [7:0] free_mask = ~(SET_MASK | CLR_MASK);
	// previous write to this register directly before, else no arming
	wire  [7:0] set_ok    = prev_ok ? (SET_MASK & ~prev & wdata) : 8'h00;
	wire  [7:0] clr_ok    = prev_ok ? (CLR_MASK & prev & ~wdata) : 8'h00;
	// free bits follow the write; set bits clear freely; lock bits set freely
	wire  [7:0] sw_val    = (wdata & free_mask)
		| ((value | set_ok) & SET_MASK & wdata)
		| ((value | wdata) & ~clr_ok & CLR_MASK);
	wire  [7:0] sw_next   = wr_hit ? sw_val : value;
	assign next_value = (sw_next & ~hw_clr) | hw_set;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			value   <= RESET_VAL;
			prev    <= 8'h00;
			prev_ok <= 1'b0;
		end else begin
			value   <= next_value;
			prev    <= wdata;
			prev_ok <= wr_hit;
			if (!wr_any) prev_ok <= prev_ok;
			if (!wr_any) prev <= prev;
		end
	end
endmodule // frc_guard
`default_nettype wire

// ---- src/frc_pkg.sv ----
// package: register map, fields, timing of the flash rewrite control block
package frc_pkg;
	localparam int          ADDR_W            = 4;
	localparam logic [3:0]  OFF_CTRL_A        = 4'h0;
	localparam logic [3:0]  OFF_CTRL_B        = 4'h4;
	localparam logic [3:0]  OFF_CTRL_C        = 4'h8;
	localparam logic [3:0]  OFF_STATE         = 4'hc;
	// flash_ctrl_reg_a
	localparam int          BIT_CPU_REWRITE   = 1;
	localparam int          BIT_LOCK_DISABLE  = 2;
	localparam int          BIT_ERASE_CMD     = 4;
	localparam int          BIT_PROG_CMD      = 5;
	// flash_ctrl_reg_b
	localparam int          BIT_LOCK_RELEASE  = 3;
	localparam int          BIT_LOCK_LO       = 4;
	localparam int          BIT_LOCK_HI       = 7;
	// flash_ctrl_reg_c
	localparam int          BIT_SUSP_EN       = 0;
	localparam int          BIT_SUSP_REQ      = 1;
	localparam int          BIT_IRQ_AUTO_SUSP = 2;
	localparam int          BIT_DF_WAIT       = 3;
	localparam int          BIT_LOW_CUR_READ  = 7;
	// flash_state_reg
	localparam int          BIT_SUSPENDED     = 6;
	localparam int          BIT_READY         = 7;
	localparam logic [7:0]  RST_CTRL_A        = 8'h00;
	localparam logic [7:0]  RST_CTRL_B        = 8'hf0;
	localparam logic [7:0]  RST_CTRL_C        = 8'h00;
	localparam logic [7:0]  SET_MASK_A        = 8'h06;
	localparam logic [7:0]  SET_MASK_B        = 8'h08;
	localparam logic [7:0]  SET_MASK_C        = 8'h85;
	localparam logic [7:0]  CLR_MASK_B        = 8'hf0;
	localparam int          CLK_MHZ           = 100;
	localparam int          DF_WAIT_CYC       = 4;
	localparam int          DF_FAST_CYC       = 1;
	localparam int          SUSP_LAT_NS       = 200;
	localparam int          SUSP_LAT_CYC      = (SUSP_LAT_NS * CLK_MHZ + 999) / 1000;
	localparam int          RECOVER_NS        = 1000;
	localparam int          RECOVER_CYC       = (RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int          ERASE_CYC         = 4000;
	localparam int          PROG_CYC          = 400;
	localparam int          CNT_W             = 16;
	typedef enum logic [2:0] {
		FRC_IDLE,
		FRC_ERASE,
		FRC_SUSP_WAIT,
		FRC_SUSPENDED,
		FRC_PROG,
		FRC_RECOVER
	} frc_state_e;
endpackage

// ---- test/frc_ctrl_asserts.sv ----
// port assertions for the flash rewrite control block
`timescale 1ns/1ps
`default_nettype none
module frc_ctrl_asserts (
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq_hold,
	input wire logic       flash_reset,
	input wire logic       watchdog_run,
	input wire logic       low_current_read,
	input wire logic [2:0] df_access_cycles
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	watchdog_on_a: assert property (watchdog_run)
		else $error("watchdog stopped");
	recover_holds_a: assert property (flash_reset |-> irq_hold)
		else $error("handler entry not held during recovery");
	recover_len_a: assert property ($rose(flash_reset) |-> ##98 flash_reset ##[1:3] !flash_reset)
		else $error("recovery period wrong length");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	unmapped_zero_a: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	df_wait_set_a: assert property (reg_wr && reg_addr == 4'h8 && reg_wdata[3]
		|-> ##[1:2] df_access_cycles == 3'h4)
		else $error("slow data flash access not applied");
	df_wait_clr_a: assert property (reg_wr && reg_addr == 4'h8 && !reg_wdata[3]
		|-> ##[1:2] df_access_cycles == 3'h1)
		else $error("fast data flash access not applied");
	low_cur_cause_a: assert property ($changed(low_current_read)
		|-> $past(reg_wr && reg_addr == 4'h8) || $past(reg_wr && reg_addr == 4'h8, 2))
		else $error("low current read changed without write");
endmodule // frc_ctrl_asserts
bind frc_ctrl frc_ctrl_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .irq_hold(irq_hold), .flash_reset(flash_reset),
	.watchdog_run(watchdog_run), .low_current_read(low_current_read),
	.df_access_cycles(df_access_cycles));
`default_nettype wire

// ---- test/tb_frc_ctrl.sv ----
// self-checking bench for the flash rewrite control block
`timescale 1ns/1ps
`default_nettype none
module tb_frc_ctrl;
	logic       clk_sys   = 1'b0;
	logic       sys_rst   = 1'b1;
	logic [3:0] reg_addr  = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic       irq_ack   = 1'b0;
	logic       is_rom    = 1'b1;
	logic [7:0] reg_rdata;
	logic       irq_hold;
	logic       flash_reset;
	logic       watchdog_run;
	logic       low_current_read;
	logic [2:0] df_access_cycles;
	logic [7:0] v;
	int         n_mismatch = 0;
	int         n_compared = 0;
	int         cycles     = 0;
	int         cnt;
	always #5 clk_sys = ~clk_sys;
	frc_ctrl #(.ERASE_CYCLES(20), .PROG_CYCLES(10)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_ack(irq_ack), .target_is_rom(is_rom),
		.ram_resident_rewrite_mode(1'b0), .rom_resident_rewrite_mode(1'b1),
		.irq_hold(irq_hold), .flash_reset(flash_reset), .watchdog_run(watchdog_run),
		.low_current_read(low_current_read), .df_access_cycles(df_access_cycles));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// polls the state register until the masked value shows up
	task automatic wait_state(input logic [7:0] m, input logic [7:0] e);
		for (int k = 0; k < 300; k++) begin
			rd(4'hc);
			if ((v & m) === e) break;
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(4'h0); chk(v, frc_pkg::RST_CTRL_A);
		rd(4'h4); chk(v, frc_pkg::RST_CTRL_B);
		rd(4'h8); chk(v, frc_pkg::RST_CTRL_C);
		rd(4'hc); chk(v, 8'h80);
		rd(4'h2); chk(v, 8'h00);
		chk({7'h0, watchdog_run}, 8'h01);
		// arming broken by a write elsewhere
		wr(4'h8, 8'h00);
		wr(4'h0, 8'h00);
		wr(4'h8, 8'h80);
		rd(4'h8); chk(v, 8'h00);
		chk({7'h0, low_current_read}, 8'h00);
		wr(4'h8, 8'h00);
		wr(4'h8, 8'h85);
		rd(4'h8); chk(v, 8'h85);
		chk({7'h0, low_current_read}, 8'h01);
		wr(4'h8, 8'h8d);
		rd(4'h8); chk(v, 8'h8d);
		chk({5'h0, df_access_cycles}, 8'h04);
		wr(4'h8, 8'h85);
		rd(4'h8); chk({5'h0, df_access_cycles}, 8'h01);
		wr(4'h4, 8'h00);
		rd(4'h4); chk(v, 8'hf0);
		wr(4'h4, 8'hf0);
		wr(4'h4, 8'h00);
		rd(4'h4); chk(v, 8'h00);
		wr(4'h4, 8'h08);
		rd(4'h4); chk(v, 8'h08);
		wr(4'h0, 8'h00);
		wr(4'h0, 8'h02);
		rd(4'h0); chk(v, 8'h02);
		// erase of program rom cut short by an interrupt
		wr(4'h0, 8'h12);
		rd(4'hc); chk(v & 8'h80, 8'h00);
		@(posedge clk_sys);
		irq_ack <= 1'b1;
		@(posedge clk_sys);
		irq_ack <= 1'b0;
		#1 chk({6'h0, irq_hold, flash_reset}, 8'h03);
		cnt = 1;
		while (flash_reset === 1'b1 && cnt < 300) begin
			@(posedge clk_sys);
			#1 if (flash_reset === 1'b1) cnt++;
		end
		chk(8'(cnt), 8'(frc_pkg::RECOVER_CYC));
		wait_state(8'h80, 8'h80);
		chk(v & 8'h80, 8'h80);
		// aborted block erased again to completion
		wr(4'h0, 8'h12);
		rd(4'hc); chk(v & 8'h80, 8'h00);
		wait_state(8'h80, 8'h80);
		chk(v & 8'h80, 8'h80);
		// one program of a fresh address
		wr(4'h0, 8'h22);
		rd(4'hc); chk(v & 8'h80, 8'h00);
		wait_state(8'h80, 8'h80);
		chk(v & 8'h80, 8'h80);
		rd(4'h0); chk(v, 8'h02);
		// data flash erase suspended by software and resumed
		@(posedge clk_sys);
		is_rom <= 1'b0;
		wr(4'h0, 8'h12);
		wr(4'h8, 8'h87);
		wait_state(8'h40, 8'h40);
		chk(v & 8'hc0, 8'hc0);
		wr(4'h8, 8'h85);
		wait_state(8'hc0, 8'h80);
		chk(v & 8'hc0, 8'h80);
		// interrupt on a data flash erase raises the suspend request itself
		wr(4'h0, 8'h12);
		@(posedge clk_sys);
		irq_ack <= 1'b1;
		#1 chk({7'h0, irq_hold}, 8'h00);
		@(posedge clk_sys);
		irq_ack <= 1'b0;
		rd(4'h8); chk(v, 8'h87);
		wait_state(8'h40, 8'h40);
		chk(v & 8'hc0, 8'hc0);
		wr(4'h8, 8'h85);
		wait_state(8'hc0, 8'h80);
		chk(v & 8'hc0, 8'h80);
		// low-current read off before any stop or wait entry
		wr(4'h8, 8'h05);
		rd(4'h8); chk(v, 8'h05);
		chk({7'h0, low_current_read}, 8'h00);
		final_report();
	end
endmodule // tb_frc_ctrl
`default_nettype wire
